// File: include/pxm_defs.svh
// Purpose: Constants for the port alternate-function and bus strobe block
// Assumes: Core clock of 20 MHz stands in for the oscillator
// Notes:   Definitions only
`ifndef PXM_DEFS_SVH
`define PXM_DEFS_SVH
`define PXM_SLOT_PERIODS     3'h6
`define PXM_SLOT_LAST        3'h5
`define PXM_INT_ROM_LIMIT    16'h1000
`define PXM_ALE_SLOT         3'h0
`define PXM_ADDR_SLOTS_END   3'h2
`define PXM_BIT_RXD          3
`define PXM_P3_RXD           0
`define PXM_P3_TXD           1
`define PXM_P3_EV0           2
`define PXM_P3_EV1           3
`define PXM_P3_CNT0          4
`define PXM_P3_CNT1          5
`define PXM_P3_WR            6
`define PXM_P3_RD            7
`define PXM_P1_RTS           6
`define PXM_P1_CTS           7
`define PXM_BYTE_ONES        8'hFF
`endif

// File: include/pxm_pkg.sv
// Purpose: Types for the port alternate-function block
// Assumes: Nothing
// Notes:   Constants live in pxm_defs.svh
package pxm_pkg;
	typedef enum logic [1:0] {
		PXM_CFG_P2P,
		PXM_CFG_MULTI,
		PXM_CFG_LOOP
	} pxm_cfg_t;
	typedef enum logic [1:0] {
		PXM_XFER_IDLE,
		PXM_XFER_FETCH,
		PXM_XFER_READ,
		PXM_XFER_WRITE
	} pxm_xfer_t;
endpackage

// File: verilog/pxm_slot_timer.sv
// Purpose: Six-period slot counter that paces the bus strobes
// Assumes: One core clock per oscillator period
// Notes:   Slot zero carries the address latch pulse
`timescale 1ns/1ns
`default_nettype none
`include "pxm_defs.svh"
module pxm_slot_timer (
	input  wire logic       clk,
	input  wire logic       rst,
	output logic [2:0]      slot,
	output logic            slot_start
);
	logic [2:0] slot_reg;

	always_ff @(posedge clk) begin
		if (rst)
			slot_reg <= 3'h0;
		else if (slot_reg == `PXM_SLOT_LAST)
			slot_reg <= 3'h0;
		else
			slot_reg <= slot_reg + 3'h1;
	end

	assign slot       = slot_reg;
	assign slot_start = (slot_reg == `PXM_ALE_SLOT);
endmodule // pxm_slot_timer
`default_nettype wire

// File: verilog/pxm_port_mux.sv
// Purpose: Port pin multiplexing and external bus strobes
// Assumes: Core supplies fetch address, data-cycle requests and latches
// Notes:   All pin outputs registered; enables high while driving
`timescale 1ns/1ns
`default_nettype none
`include "pxm_defs.svh"
module pxm_port_mux
	import pxm_pkg::*;
#(
	parameter int ADDR_W = 16
) (
	input  wire logic              CORE_CLK,
	input  wire logic              SYS_RST,
	input  wire logic              EXTERNAL_FETCH_SELECT,
	input  wire logic [ADDR_W-1:0] FETCH_ADDR,
	input  wire logic              DATA_READ_REQ,
	input  wire logic              DATA_WRITE_REQ,
	input  wire logic [ADDR_W-1:0] DATA_ADDR,
	input  wire logic [7:0]        DATA_WDATA,
	output logic [7:0]             DATA_RDATA,
	output logic                   DATA_RDATA_VALID,
	output logic [7:0]             CODE_RDATA,
	output logic                   CODE_RDATA_VALID,
	input  wire logic [7:0]        P0_LATCH,
	input  wire logic [7:0]        P1_LATCH,
	input  wire logic [7:0]        P2_LATCH,
	input  wire logic [7:0]        P3_LATCH,
	input  wire logic [1:0]        LINK_CFG,
	input  wire logic              LINK_READY_TX,
	input  wire logic              LINK_TXD,
	input  wire logic              LINK_DATA_OUT_EN,
	input  wire logic              BUS_STALL,
	output logic                   LINK_RXD,
	output logic                   LINK_CLEAR_TO_SEND,
	output logic                   LINK_DIAG_MODE,
	output logic                   LINK_BIT_CLK,
	output logic                   EXTERNAL_EVENT_LINE_0,
	output logic                   EXTERNAL_EVENT_LINE_1,
	output logic                   COUNTER0_COUNT_INPUT,
	output logic                   COUNTER1_COUNT_INPUT,
	output logic                   FETCH_EXTERNAL,
	input  wire logic [7:0]        P0_IN,
	output logic [7:0]             P0_OUT,
	output logic [7:0]             P0_OE,
	input  wire logic [7:0]        P1_IN,
	output logic [7:0]             P1_OUT,
	output logic [7:0]             P1_OE,
	input  wire logic [7:0]        P2_IN,
	output logic [7:0]             P2_OUT,
	output logic [7:0]             P2_OE,
	input  wire logic [7:0]        P3_IN,
	output logic [7:0]             P3_OUT,
	output logic [7:0]             P3_OE,
	output logic                   ADDR_LATCH_STROBE,
	output logic                   PROGRAM_FETCH_STROBE,
	output logic                   RESET_ACTIVE
);
	// ------------------------------------------------------------
	// Slot pacing
	// ------------------------------------------------------------
	logic [2:0] slot;
	logic       slot_start;
	logic       ext_fetch;
	logic       loop_mode;
	logic       diag_mode;
	pxm_xfer_t  xfer_reg;
	pxm_xfer_t  xfer_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [7:0]        wdata_reg;
	logic [ADDR_W-1:0] addr_next;

	pxm_slot_timer u_slot (
		.clk        (CORE_CLK),
		.rst        (SYS_RST),
		.slot       (slot),
		.slot_start (slot_start)
	);

	// Internal ROM below the limit only with select high
	assign ext_fetch = !EXTERNAL_FETCH_SELECT ||
		(FETCH_ADDR >= ADDR_W'(`PXM_INT_ROM_LIMIT));
	assign loop_mode = (pxm_cfg_t'(LINK_CFG) == PXM_CFG_LOOP);
	assign diag_mode = !P3_LATCH[`PXM_P3_TXD];

	function automatic logic alt_on(input logic [7:0] latch, input int b);
		alt_on = latch[b];
	endfunction

	// ------------------------------------------------------------
	// Transfer kind, chosen at slot start
	// ------------------------------------------------------------
	always_comb begin
		xfer_next = xfer_reg;
		if (slot_start && BUS_STALL)
			xfer_next = PXM_XFER_IDLE;
		else if (slot_start) begin
			if (DATA_READ_REQ && alt_on(P3_LATCH, `PXM_P3_RD))
				xfer_next = PXM_XFER_READ;
			else if (DATA_WRITE_REQ && alt_on(P3_LATCH, `PXM_P3_WR))
				xfer_next = PXM_XFER_WRITE;
			else if (ext_fetch)
				xfer_next = PXM_XFER_FETCH;
			else
				xfer_next = PXM_XFER_IDLE;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			xfer_reg  <= PXM_XFER_IDLE;
			addr_reg  <= '0;
			wdata_reg <= 8'h00;
		end else begin
			xfer_reg <= xfer_next;
			if (slot_start) begin
				addr_reg  <= addr_next;
				wdata_reg <= DATA_WDATA;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST)
			RESET_ACTIVE <= 1'b1;
		else
			RESET_ACTIVE <= 1'b0;
	end

	// ------------------------------------------------------------
	// Bus strobes and ports 0 and 2
	// ------------------------------------------------------------
	logic data_cyc;
	logic addr_phase;
	assign data_cyc   = (xfer_next == PXM_XFER_READ) ||
		(xfer_next == PXM_XFER_WRITE);
	assign addr_phase = (slot < `PXM_ADDR_SLOTS_END);
	// Refused data requests must not steer the fetch address
	assign addr_next  = data_cyc ? DATA_ADDR : FETCH_ADDR;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ADDR_LATCH_STROBE    <= 1'b0;
			PROGRAM_FETCH_STROBE <= 1'b1;
			FETCH_EXTERNAL       <= 1'b0;
		end else begin
			// Pulse at slot start, dropped for data cycles
			ADDR_LATCH_STROBE <= slot_start && !BUS_STALL &&
				!data_cyc;
			// Low after address phase of an external fetch only
			PROGRAM_FETCH_STROBE <= !((xfer_reg == PXM_XFER_FETCH) &&
				!addr_phase);
			FETCH_EXTERNAL <= ext_fetch;
		end
	end

	logic ext_bus;
	assign ext_bus = (xfer_reg != PXM_XFER_IDLE);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			P0_OUT <= `PXM_BYTE_ONES;
			P0_OE  <= 8'h00;
			P2_OUT <= `PXM_BYTE_ONES;
			P2_OE  <= 8'h00;
		end else if (slot_start && (xfer_next != PXM_XFER_IDLE)) begin
			// New address stands while the latch pulse is high
			P2_OUT <= addr_next[ADDR_W-1 -: 8];
			P2_OE  <= `PXM_BYTE_ONES;
			P0_OUT <= addr_next[7:0];
			P0_OE  <= `PXM_BYTE_ONES;
		end else if (ext_bus && !slot_start) begin
			P2_OUT <= addr_reg[ADDR_W-1 -: 8];
			P2_OE  <= `PXM_BYTE_ONES;
			if (addr_phase) begin
				P0_OUT <= addr_reg[7:0];
				P0_OE  <= `PXM_BYTE_ONES;
			end else if (xfer_reg == PXM_XFER_WRITE) begin
				P0_OUT <= wdata_reg;
				P0_OE  <= `PXM_BYTE_ONES;
			end else begin
				P0_OUT <= 8'h00;
				P0_OE  <= 8'h00;
			end
		end else begin
			// Open drain: drive only the zeros
			P0_OUT <= P0_LATCH;
			P0_OE  <= ~P0_LATCH;
			P2_OUT <= P2_LATCH;
			P2_OE  <= ~P2_LATCH;
		end
	end

	// Sample returned byte in the last slot
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			DATA_RDATA       <= 8'h00;
			DATA_RDATA_VALID <= 1'b0;
			CODE_RDATA       <= 8'h00;
			CODE_RDATA_VALID <= 1'b0;
		end else begin
			DATA_RDATA_VALID <= 1'b0;
			CODE_RDATA_VALID <= 1'b0;
			if (slot == `PXM_SLOT_LAST) begin
				if (xfer_reg == PXM_XFER_READ) begin
					DATA_RDATA       <= P0_IN;
					DATA_RDATA_VALID <= 1'b1;
				end
				if (xfer_reg == PXM_XFER_FETCH) begin
					CODE_RDATA       <= P0_IN;
					CODE_RDATA_VALID <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Port 1: handshake lines
	// ------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			P1_OUT             <= `PXM_BYTE_ONES;
			P1_OE              <= 8'h00;
			LINK_CLEAR_TO_SEND <= 1'b0;
		end else begin
			P1_OUT <= P1_LATCH;
			P1_OE  <= ~P1_LATCH;
			LINK_CLEAR_TO_SEND <= 1'b0;
			if (!loop_mode) begin
				P1_OUT[`PXM_P1_RTS] <= !LINK_READY_TX;
				P1_OE[`PXM_P1_RTS]  <= LINK_READY_TX;
				P1_OUT[`PXM_P1_CTS] <= 1'b1;
				P1_OE[`PXM_P1_CTS]  <= 1'b0;
				LINK_CLEAR_TO_SEND  <= !P1_IN[`PXM_P1_CTS];
			end
		end
	end

	// ------------------------------------------------------------
	// Port 3: serial, events, counters, strobes
	// ------------------------------------------------------------
	logic txd_drive;
	assign txd_drive = loop_mode ||
		(P3_IN[`PXM_P3_RXD] && LINK_DATA_OUT_EN);

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			P3_OUT <= `PXM_BYTE_ONES;
			P3_OE  <= 8'h00;
		end else begin
			P3_OUT <= P3_LATCH;
			P3_OE  <= ~P3_LATCH;
			P3_OUT[`PXM_P3_RXD] <= 1'b1;
			P3_OE[`PXM_P3_RXD]  <= 1'b0;
			if (!diag_mode) begin
				P3_OUT[`PXM_P3_TXD] <= LINK_TXD;
				P3_OE[`PXM_P3_TXD]  <= txd_drive && !LINK_TXD;
			end
			if (alt_on(P3_LATCH, `PXM_P3_WR)) begin
				P3_OUT[`PXM_P3_WR] <= !((xfer_reg == PXM_XFER_WRITE) &&
					!addr_phase);
				P3_OE[`PXM_P3_WR]  <= (xfer_reg == PXM_XFER_WRITE) &&
					!addr_phase;
			end
			if (alt_on(P3_LATCH, `PXM_P3_RD)) begin
				P3_OUT[`PXM_P3_RD] <= !((xfer_reg == PXM_XFER_READ) &&
					!addr_phase);
				P3_OE[`PXM_P3_RD]  <= (xfer_reg == PXM_XFER_READ) &&
					!addr_phase;
			end
		end
	end

	// Inputs to the core; event lines forced high, counter inputs and bit clock forced low when role disabled
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			LINK_RXD              <= 1'b1;
			LINK_DIAG_MODE        <= 1'b0;
			LINK_BIT_CLK          <= 1'b0;
			EXTERNAL_EVENT_LINE_0 <= 1'b1;
			EXTERNAL_EVENT_LINE_1 <= 1'b1;
			COUNTER0_COUNT_INPUT  <= 1'b0;
			COUNTER1_COUNT_INPUT  <= 1'b0;
		end else begin
			LINK_DIAG_MODE <= diag_mode;
			LINK_RXD <= (loop_mode || diag_mode) ?
				P3_IN[`PXM_P3_RXD] : P3_IN[`PXM_P3_TXD];
			EXTERNAL_EVENT_LINE_0 <= !alt_on(P3_LATCH, `PXM_P3_EV0) ||
				P3_IN[`PXM_P3_EV0];
			EXTERNAL_EVENT_LINE_1 <= !alt_on(P3_LATCH, `PXM_P3_EV1) ||
				P3_IN[`PXM_P3_EV1];
			COUNTER0_COUNT_INPUT <= alt_on(P3_LATCH, `PXM_P3_CNT0) &&
				P3_IN[`PXM_P3_CNT0];
			COUNTER1_COUNT_INPUT <= alt_on(P3_LATCH, `PXM_P3_CNT1) &&
				P3_IN[`PXM_P3_CNT1];
			LINK_BIT_CLK <= alt_on(P3_LATCH, `PXM_P3_CNT1) &&
				P3_IN[`PXM_P3_CNT1];
		end
	end
endmodule // pxm_port_mux
`default_nettype wire

// File: testbench/pxm_port_mux_assertions.sv
// Purpose: Port mux assertions
// Assumes: Top module ports only
// Notes:   Bound below
`timescale 1ns/1ns
`default_nettype none
module pxm_port_mux_assertions (
	input wire logic       CORE_CLK,
	input wire logic       SYS_RST,
	input wire logic [1:0] LINK_CFG,
	input wire logic       LINK_READY_TX,
	input wire logic [7:0] P1_IN,
	input wire logic [7:0] P3_LATCH,
	input wire logic [7:0] P0_OE,
	input wire logic [7:0] P1_OUT,
	input wire logic [7:0] P1_OE,
	input wire logic [7:0] P3_OUT,
	input wire logic       LINK_CLEAR_TO_SEND,
	input wire logic       LINK_DIAG_MODE,
	input wire logic       ADDR_LATCH_STROBE,
	input wire logic       PROGRAM_FETCH_STROBE,
	input wire logic       RESET_ACTIVE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	a_ale_spacing: assert property (
		ADDR_LATCH_STROBE |=> !ADDR_LATCH_STROBE [*5])
		else $error("address latch pulses too close");
	a_fetch_width: assert property (
		$fell(PROGRAM_FETCH_STROBE) |-> !PROGRAM_FETCH_STROBE [*4]
		##1 PROGRAM_FETCH_STROBE) else $error("fetch strobe width");
	a_fetch_after_ale: assert property (
		$fell(PROGRAM_FETCH_STROBE) |-> $past(ADDR_LATCH_STROBE, 2))
		else $error("fetch strobe without address latch");
	a_read_strobe: assert property (
		$fell(P3_OUT[7]) && $past(P3_LATCH[7]) |->
		!$past(ADDR_LATCH_STROBE, 2) ##0 !P3_OUT[7] [*4] ##1 P3_OUT[7])
		else $error("read strobe wrong");
	a_write_strobe: assert property (
		$fell(P3_OUT[6]) && $past(P3_LATCH[6]) |->
		!P3_OUT[6] [*4] ##1 P3_OUT[6]) else $error("write strobe wrong");
	a_rts_level: assert property (
		!$past(SYS_RST) && $past(LINK_CFG) != 2'h2 |->
		(P1_OUT[6] | ~P1_OE[6]) == !$past(LINK_READY_TX))
		else $error("request to send wrong");
	a_cts_follow: assert property (
		!$past(SYS_RST) && $past(LINK_CFG) != 2'h2 |->
		LINK_CLEAR_TO_SEND == !$past(P1_IN[7]))
		else $error("clear to send wrong");
	a_diag_flag: assert property (
		!$past(SYS_RST) |-> LINK_DIAG_MODE == !$past(P3_LATCH[1]))
		else $error("diagnostic flag wrong");
	a_reset_state: assert property (disable iff (1'b0)
		SYS_RST |=> RESET_ACTIVE && !ADDR_LATCH_STROBE
		&& PROGRAM_FETCH_STROBE && P0_OE == 8'h00)
		else $error("reset state wrong");
	cover property ($fell(P3_OUT[7]));
	cover property ($fell(P3_OUT[6]));
	cover property ($fell(PROGRAM_FETCH_STROBE));
endmodule // pxm_port_mux_assertions
bind pxm_port_mux pxm_port_mux_assertions i_pxm_port_mux_assertions (
	.CORE_CLK, .SYS_RST, .LINK_CFG, .LINK_READY_TX, .P1_IN, .P3_LATCH,
	.P0_OE, .P1_OUT, .P1_OE, .P3_OUT, .LINK_CLEAR_TO_SEND,
	.LINK_DIAG_MODE, .ADDR_LATCH_STROBE, .PROGRAM_FETCH_STROBE,
	.RESET_ACTIVE);
`default_nettype wire

// File: testbench/pxm_ext_mem_model.sv
// Purpose: External program and data memory
// Assumes: Address taken when port 0 starts driving
// Notes:   Released bus reads as pull-up
`timescale 1ns/1ns
`default_nettype none
module pxm_ext_mem_model (
	input  wire logic       clk,
	input  wire logic       ale,
	input  wire logic       fetch_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] addr_hi,
	input  wire logic [7:0] bus_out,
	input  wire logic [7:0] bus_oe,
	output logic      [7:0] bus_drv,
	output logic            bus_en
);
	logic [7:0] mem [256];
	logic [7:0] lo, hi;
	logic       oe_q;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
	initial oe_q = 1'b0;
	always @(posedge clk) begin
		oe_q <= &bus_oe;
		if (ale || (&bus_oe && !oe_q)) begin
			lo <= bus_out;
			hi <= addr_hi;
		end
		if (!wr_n) mem[lo ^ hi] <= bus_out;
	end
	assign bus_en = !fetch_n || !rd_n;
	assign bus_drv = bus_en ? mem[lo ^ hi] : 8'hFF;
endmodule // pxm_ext_mem_model
`default_nettype wire

// File: testbench/pxm_port_mux_bench.sv
// Purpose: Self-checking bench for the port mux
// Assumes: Pull-ups on all port pins
// Notes:   Table rows cover pin roles
`timescale 1ns/1ns
`default_nettype none
module pxm_port_mux_bench;
	logic        CORE_CLK, SYS_RST, EXTERNAL_FETCH_SELECT, BUS_STALL;
	logic        DATA_READ_REQ, DATA_WRITE_REQ, LINK_READY_TX;
	logic        LINK_TXD, LINK_DATA_OUT_EN;
	logic [15:0] FETCH_ADDR, DATA_ADDR;
	logic [7:0]  DATA_WDATA, P3_LATCH, p1_ext, p3_ext, m_drv;
	logic [1:0]  LINK_CFG;
	logic [7:0]  DATA_RDATA, CODE_RDATA, P0_OUT, P0_OE, P1_OUT, P1_OE;
	logic [7:0]  P2_OUT, P2_OE, P3_OUT, P3_OE;
	logic        DATA_RDATA_VALID, CODE_RDATA_VALID, LINK_RXD, m_en;
	logic        LINK_CLEAR_TO_SEND, LINK_DIAG_MODE, LINK_BIT_CLK;
	logic        EXTERNAL_EVENT_LINE_0, EXTERNAL_EVENT_LINE_1;
	logic        COUNTER0_COUNT_INPUT, COUNTER1_COUNT_INPUT;
	logic        FETCH_EXTERNAL, ADDR_LATCH_STROBE, PROGRAM_FETCH_STROBE;
	logic        RESET_ACTIVE;
	int          failures, samples_checked;
	wire logic [7:0] P0_IN = (P0_OUT | ~P0_OE) & m_drv;
	wire logic [7:0] P1_IN = (P1_OUT | ~P1_OE) & p1_ext;
	wire logic [7:0] P2_IN = P2_OUT | ~P2_OE;
	wire logic [7:0] P3_IN = (P3_OUT | ~P3_OE) & p3_ext;
	logic [24:0] rows [5] = '{
		{8'hFF, 8'hFF, 2'h0, 7'h7D}, {8'hFF, 8'hEA, 2'h2, 7'h29},
		{8'hC3, 8'hFF, 2'h1, 7'h64}, {8'hFD, 8'hFE, 2'h0, 7'h7B},
		{8'hFD, 8'hFF, 2'h0, 7'h7F}};
	pxm_port_mux i_pxm_port_mux (
		.CORE_CLK, .SYS_RST, .EXTERNAL_FETCH_SELECT, .FETCH_ADDR,
		.DATA_READ_REQ, .DATA_WRITE_REQ, .DATA_ADDR, .DATA_WDATA,
		.DATA_RDATA, .DATA_RDATA_VALID, .CODE_RDATA, .CODE_RDATA_VALID,
		.P0_LATCH(8'hFF), .P1_LATCH(8'hFF), .P2_LATCH(8'hFF), .P3_LATCH,
		.LINK_CFG, .LINK_READY_TX, .LINK_TXD,
		.LINK_DATA_OUT_EN, .BUS_STALL, .LINK_RXD,
		.LINK_CLEAR_TO_SEND, .LINK_DIAG_MODE, .LINK_BIT_CLK,
		.EXTERNAL_EVENT_LINE_0, .EXTERNAL_EVENT_LINE_1,
		.COUNTER0_COUNT_INPUT, .COUNTER1_COUNT_INPUT, .FETCH_EXTERNAL,
		.P0_IN, .P0_OUT, .P0_OE, .P1_IN, .P1_OUT, .P1_OE,
		.P2_IN, .P2_OUT, .P2_OE, .P3_IN, .P3_OUT, .P3_OE,
		.ADDR_LATCH_STROBE, .PROGRAM_FETCH_STROBE, .RESET_ACTIVE);
	pxm_ext_mem_model i_pxm_ext_mem_model (.clk(CORE_CLK),
		.ale(ADDR_LATCH_STROBE), .fetch_n(PROGRAM_FETCH_STROBE),
		.rd_n(P3_IN[7]), .wr_n(P3_IN[6]), .addr_hi(P2_IN),
		.bus_out(P0_OUT), .bus_oe(P0_OE), .bus_drv(m_drv), .bus_en(m_en));
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task reset_check;
		@(posedge CORE_CLK);
		@(negedge CORE_CLK);
		chk({RESET_ACTIVE, PROGRAM_FETCH_STROBE, ADDR_LATCH_STROBE, 5'h0},
			8'hC0);
		chk(P0_OE, 8'h00);
	endtask
	// Sel, fetch address, stall, address latch pulses in 24 cycles
	task fetch(input logic s, input logic [15:0] a, input logic t,
		input logic [7:0] n);
		logic [7:0] na, nf, nc;
		logic       ex;
		na = 8'h00;
		nf = 8'h00;
		nc = 8'h00;
		ex = (!s || a >= 16'h1000) && !t;
		@(posedge CORE_CLK);
		EXTERNAL_FETCH_SELECT <= s;
		FETCH_ADDR <= a;
		BUS_STALL <= t;
		repeat (12) @(posedge CORE_CLK);
		repeat (24) begin
			@(negedge CORE_CLK);
			na += {7'h0, ADDR_LATCH_STROBE};
			nf += {7'h0, !PROGRAM_FETCH_STROBE};
			nc += {7'h0, CODE_RDATA_VALID};
		end
		chk(na, n);
		chk(nf, ex ? 8'h10 : 8'h00);
		chk(nc, ex ? 8'h04 : 8'h00);
		chk({7'h0, FETCH_EXTERNAL}, {7'h0, !s || a >= 16'h1000});
		if (ex)
			chk(CODE_RDATA, a[7:0] ^ a[15:8] ^ 8'hA5);
		$display("fetch test done at %h", a);
	endtask
	// Write flag, address, write byte, expected read byte, port 3 latch
	task data(input logic w, input logic [15:0] a, input logic [7:0] d,
		input logic [7:0] e, input logic [7:0] lat);
		logic [7:0] nv, ns;
		logic       ok;
		nv = 8'h00;
		ns = 8'h00;
		ok = lat[7 - w];
		@(posedge CORE_CLK);
		P3_LATCH <= lat;
		DATA_ADDR <= a;
		DATA_WDATA <= d;
		DATA_WRITE_REQ <= w;
		DATA_READ_REQ <= !w;
		for (int k = 0; k < 18; k++) begin
			@(posedge CORE_CLK);
			if (k == 5) begin
				DATA_WRITE_REQ <= 1'b0;
				DATA_READ_REQ <= 1'b0;
			end
			@(negedge CORE_CLK);
			nv += {7'h0, DATA_RDATA_VALID};
			ns += {7'h0, !P3_IN[7 - w]};
		end
		chk(nv, {7'h0, ok & !w});
		if (ok)
			chk(ns, 8'h04);
		if (ok && !w)
			chk(DATA_RDATA, e);
		$display("data test done at %h", a);
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #25 CORE_CLK = ~CORE_CLK;
	end
	initial begin
		repeat (2000) @(posedge CORE_CLK);
		failures++;
		$display("ERROR %0t got %h exp %h", $time, 8'h00, 8'h01);
		close_out;
	end
	initial begin
		failures = 0;
		samples_checked = 0;
		SYS_RST = 1'b1;
		EXTERNAL_FETCH_SELECT = 1'b1;
		BUS_STALL = 1'b0;
		DATA_READ_REQ = 1'b0;
		DATA_WRITE_REQ = 1'b0;
		LINK_READY_TX = 1'b0;
		LINK_TXD = 1'b0;
		LINK_DATA_OUT_EN = 1'b0;
		FETCH_ADDR = 16'h0000;
		DATA_ADDR = 16'h0000;
		DATA_WDATA = 8'h00;
		P3_LATCH = 8'hFF;
		p1_ext = 8'hFF;
		p3_ext = 8'hFF;
		LINK_CFG = 2'h0;
		repeat (16) @(posedge CORE_CLK);
		reset_check();
		@(posedge CORE_CLK);
		SYS_RST <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			@(posedge CORE_CLK);
			{P3_LATCH, p3_ext, LINK_CFG} <= rows[i][24:7];
			LINK_READY_TX <= i[0];
			p1_ext <= {i[1], 7'h7F};
			repeat (3) @(negedge CORE_CLK);
			chk({1'b0, EXTERNAL_EVENT_LINE_0, EXTERNAL_EVENT_LINE_1,
				COUNTER0_COUNT_INPUT, COUNTER1_COUNT_INPUT, LINK_RXD,
				LINK_DIAG_MODE, LINK_BIT_CLK},
				{1'b0, rows[i][6:0]});
			chk({6'h0, LINK_CLEAR_TO_SEND, P1_IN[6]},
				(rows[i][8:7] == 2'h2) ? 8'h01 :
				{6'h0, !i[1], !i[0]});
		end
		$display("pin role table done");
		@(posedge CORE_CLK);
		{P3_LATCH, p3_ext, LINK_CFG} <= {8'hFF, 8'hFF, 2'h0};
		LINK_DATA_OUT_EN <= 1'b1;
		repeat (3) @(negedge CORE_CLK);
		chk({7'h0, P3_IN[1]}, 8'h00);
		@(posedge CORE_CLK);
		LINK_TXD <= 1'b1;
		repeat (3) @(negedge CORE_CLK);
		chk({7'h0, P3_IN[1]}, 8'h01);
		@(posedge CORE_CLK);
		{LINK_TXD, p3_ext} <= {1'b0, 8'hFE};
		repeat (3) @(negedge CORE_CLK);
		chk({7'h0, P3_IN[1]}, 8'h01);
		@(posedge CORE_CLK);
		{p3_ext, LINK_DATA_OUT_EN} <= {8'hFF, 1'b0};
		$display("link direction done");
		fetch(1'b1, 16'h0FFF, 1'b0, 8'h04);
		fetch(1'b1, 16'h1000, 1'b0, 8'h04);
		fetch(1'b0, 16'h0010, 1'b1, 8'h00);
		fetch(1'b0, 16'h0010, 1'b0, 8'h04);
		data(1'b0, 16'h12C4, 8'h00, 8'h73, 8'hFF);
		data(1'b1, 16'h12C4, 8'h3C, 8'h00, 8'hFF);
		data(1'b0, 16'h12C4, 8'h00, 8'h3C, 8'hFF);
		data(1'b0, 16'h12C4, 8'h00, 8'h00, 8'h7F);
		@(posedge CORE_CLK);
		SYS_RST <= 1'b1;
		reset_check();
		$display("second reset done");
		close_out;
	end
endmodule // pxm_port_mux_bench
`default_nettype wire
